// file: pkg/csp_params.svh
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

// Register port
`define CSP_ADDR_W          6
`define CSP_DATA_W          4
`define CSP_OFF_PINFN       6'h04
`define CSP_OFF_MODE_A      6'h05
`define CSP_OFF_SR_LO       6'h06
`define CSP_OFF_SR_HI       6'h07
`define CSP_OFF_MISC        6'h0c
`define CSP_OFF_IDLE_CTL    6'h28
`define CSP_OFF_START       6'h2b
`define CSP_OFF_IRQ_STAT    6'h30
`define CSP_OFF_IRQ_MASK    6'h31
`define CSP_OFF_STATUS      6'h32

// Field positions
`define CSP_PINFN_OUT_BIT   0
`define CSP_PINFN_IN_BIT    1
`define CSP_MISC_PULL_BIT   3
`define CSP_IDLE_LEVEL_BIT  1
`define CSP_START_BIT       0
`define CSP_IRQ_XFER_BIT    0
`define CSP_IRQ_TICK_BIT    1

// Reset values and codes
`define CSP_PINFN_RST       2'h0
`define CSP_MISC_RST        3'h0
`define CSP_MODE_RST        4'h0
`define CSP_CLK_SRC_EXT     3'h7
`define CSP_TSEL_LONG       2'h1
`define CSP_BIT_LAST        3'h7

// Timing
`define CSP_CLK_NS          50
`define CSP_TRC_SHORT_NS    122070
`define CSP_TRC_LONG_NS     244140
`define CSP_INT_HALF_CYC    4

`endif

// file: pkg/csp_pkg.sv
package csp_pkg;

	typedef enum logic [1:0] {
		CSP_STS_WAIT,
		CSP_CLK_WAIT,
		CSP_XFER
	} csp_state_t;

	typedef struct packed {
		logic       sck_pin_sel;
		logic [2:0] clk_src;
	} csp_mode_t;

	typedef struct packed {
		logic input_pin_function_bit;
		logic output_pin_function_bit;
	} csp_pinfn_t;

	typedef struct packed {
		logic       pull_transistor_enable;
		logic       timing_select_high;
		logic       timing_select_low;
	} csp_misc_t;

endpackage

// file: hw/csp_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser; also used to release the reset
module csp_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= RST_VAL;
			q_out  <= RST_VAL;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end

endmodule

// file: hw/csp_top.sv
`timescale 1ns/100ps
`include "csp_params.svh"
module csp_top
	import csp_pkg::*;
#(
	parameter int TRC_LONG_CYC = `CSP_TRC_LONG_NS / `CSP_CLK_NS,
	parameter int INT_HALF_CYC = `CSP_INT_HALF_CYC
) (
	// Clock and reset
	input  wire logic                   SYS_CLK_IN,
	input  wire logic                   ARST_N_IN,
	// Register port
	input  wire logic [`CSP_ADDR_W-1:0] REG_ADDR_IN,
	input  wire logic [`CSP_DATA_W-1:0] REG_WDATA_IN,
	input  wire logic                   REG_WR_IN,
	input  wire logic                   REG_RD_IN,
	output logic      [`CSP_DATA_W-1:0] REG_RDATA_OUT,
	// Power state
	input  wire logic                   STOP_MODE_IN,
	// Serial link pins
	input  wire logic                   TRANSFER_CLOCK_PIN_IN,
	output logic                        TRANSFER_CLOCK_PIN_OUT,
	output logic                        TRANSFER_CLOCK_PIN_OE_OUT,
	input  wire logic                   SERIAL_IN_PIN_IN,
	output logic                        SERIAL_OUT_PIN_OUT,
	output logic                        PULL_TRANSISTOR_ENABLE_OUT,
	// General port sharing
	input  wire logic                   SHARED_OUTPUT_PORT_DATA_IN,
	output logic                        SHARED_INPUT_PORT_DATA_OUT,
	// Events
	output logic                        TIMING_TICK_OUT,
	output logic                        IRQ_OUT
);

	localparam int TRC_SHORT_CYC = `CSP_TRC_SHORT_NS / `CSP_CLK_NS;
	localparam int TW            = $clog2(TRC_LONG_CYC + TRC_SHORT_CYC + 1);
	localparam int HW            = $clog2(INT_HALF_CYC + 1);

	logic             rst_n;
	logic             clk_pin_s;
	logic             si_s;
	csp_state_t       state_q;
	csp_mode_t        mode_q;
	csp_pinfn_t       pinfn_q;
	csp_misc_t        misc_q;
	logic             idle_q;
	logic [2:0]       cnt_q;
	logic [7:0]       sr_q;
	logic             so_bit_q;
	logic             run_q;
	logic [HW-1:0]    hc_q;
	logic             clk_int_q;
	logic             tclk;
	logic             tclk_prev_q;
	logic             tclk_fall;
	logic             tclk_rise;
	logic             ext_mode;
	logic [TW-1:0]    tcnt_q;
	logic [TW-1:0]    per_last;
	logic             tick_q;
	logic [1:0]       stat_q;
	logic [1:0]       mask_q;
	logic [1:0]       stat_set;
	logic             wr_pinfn;
	logic             wr_mode;
	logic             wr_misc;
	logic             wr_idle;
	logic             wr_start;
	logic             wr_sr_lo;
	logic             wr_sr_hi;
	logic             wrap;
	logic             si_eff;

	// Reset release and pin synchronisers
	csp_sync #(
		.W       (1),
		.RST_VAL (1'b0)
	) u_rst_sync (
		.clk_in   (SYS_CLK_IN),
		.rst_n_in (ARST_N_IN),
		.d_in     (1'b1),
		.q_out    (rst_n)
	);

	csp_sync #(
		.W       (2),
		.RST_VAL (2'h3)
	) u_pin_sync (
		.clk_in   (SYS_CLK_IN),
		.rst_n_in (rst_n),
		.d_in     ({TRANSFER_CLOCK_PIN_IN, SERIAL_IN_PIN_IN}),
		.q_out    ({clk_pin_s, si_s})
	);

	// Write decode
	assign wr_pinfn = REG_WR_IN && (REG_ADDR_IN == `CSP_OFF_PINFN);
	assign wr_mode  = REG_WR_IN && (REG_ADDR_IN == `CSP_OFF_MODE_A);
	assign wr_misc  = REG_WR_IN && (REG_ADDR_IN == `CSP_OFF_MISC);
	assign wr_idle  = REG_WR_IN && (REG_ADDR_IN == `CSP_OFF_IDLE_CTL);
	assign wr_start = REG_WR_IN && (REG_ADDR_IN == `CSP_OFF_START) && REG_WDATA_IN[`CSP_START_BIT];
	assign wr_sr_lo = REG_WR_IN && (REG_ADDR_IN == `CSP_OFF_SR_LO);
	assign wr_sr_hi = REG_WR_IN && (REG_ADDR_IN == `CSP_OFF_SR_HI);

	// Control registers, cleared by stop mode as well as reset
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			pinfn_q <= `CSP_PINFN_RST;
			misc_q  <= `CSP_MISC_RST;
			mode_q  <= `CSP_MODE_RST;
		end else if (STOP_MODE_IN) begin
			pinfn_q <= `CSP_PINFN_RST;
			misc_q  <= `CSP_MISC_RST;
			mode_q  <= `CSP_MODE_RST;
		end else begin
			if (wr_pinfn) begin
				pinfn_q <= REG_WDATA_IN[1:0];
			end
			if (wr_misc) begin
				misc_q <= {REG_WDATA_IN[`CSP_MISC_PULL_BIT], REG_WDATA_IN[1:0]};
			end
			if (wr_mode) begin
				mode_q <= REG_WDATA_IN;
			end
		end
	end

	// Idle level has no documented reset; defined low here. Locked during transfer.
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			idle_q <= 1'b0;
		end else if (wr_idle && state_q != CSP_XFER) begin
			idle_q <= REG_WDATA_IN[`CSP_IDLE_LEVEL_BIT];
		end
	end

	// Transfer clock source and edge detect
	assign ext_mode  = (mode_q.clk_src == `CSP_CLK_SRC_EXT);
	assign tclk      = ext_mode ? (clk_pin_s | ~mode_q.sck_pin_sel) : clk_int_q;
	assign tclk_fall = tclk_prev_q & ~tclk;
	assign tclk_rise = ~tclk_prev_q & tclk;
	assign wrap      = (state_q == CSP_XFER) && tclk_rise && (cnt_q == `CSP_BIT_LAST);

	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			tclk_prev_q <= 1'b1;
		end else begin
			tclk_prev_q <= tclk;
		end
	end

	// Internal clock runs only from a start until the byte wraps
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			run_q     <= 1'b0;
			hc_q      <= '0;
			clk_int_q <= 1'b1;
		end else if (STOP_MODE_IN || wr_mode || wrap) begin
			run_q     <= 1'b0;
			hc_q      <= '0;
			clk_int_q <= 1'b1;
		end else begin
			if (wr_start && !ext_mode) begin
				run_q <= 1'b1;
			end
			if (run_q) begin
				if (hc_q == HW'(INT_HALF_CYC - 1)) begin
					hc_q      <= '0;
					clk_int_q <= ~clk_int_q;
				end else begin
					hc_q <= hc_q + 1'b1;
				end
			end
		end
	end

	// Transfer state machine
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= CSP_STS_WAIT;
		end else if (STOP_MODE_IN || wr_mode) begin
			state_q <= CSP_STS_WAIT;
		end else begin
			unique case (state_q)
				CSP_STS_WAIT: begin
					if (wr_start) begin
						state_q <= CSP_CLK_WAIT;
					end
				end
				CSP_CLK_WAIT: begin
					if (tclk_fall) begin
						state_q <= CSP_XFER;
					end
				end
				CSP_XFER: begin
					if (wrap) begin
						state_q <= CSP_CLK_WAIT;
					end
				end
			endcase
		end
	end

	// Octal bit counter
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (STOP_MODE_IN || wr_mode) begin
			cnt_q <= '0;
		end else if (state_q == CSP_XFER && tclk_rise) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// Shift register; shifting beats a software write in the same cycle
	assign si_eff = pinfn_q.input_pin_function_bit & si_s;
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			sr_q <= '0;
		end else if (state_q == CSP_XFER && tclk_rise) begin
			sr_q <= {si_eff, sr_q[7:1]};
		end else begin
			if (wr_sr_lo) begin
				sr_q[3:0] <= REG_WDATA_IN;
			end
			if (wr_sr_hi) begin
				sr_q[7:4] <= REG_WDATA_IN;
			end
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			so_bit_q <= 1'b0;
		end else if (tclk_fall && state_q != CSP_STS_WAIT) begin
			so_bit_q <= sr_q[0];
		end
	end

	// Pin outputs
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			SERIAL_OUT_PIN_OUT         <= 1'b0;
			SHARED_INPUT_PORT_DATA_OUT <= 1'b1;
			TRANSFER_CLOCK_PIN_OUT     <= 1'b1;
			TRANSFER_CLOCK_PIN_OE_OUT  <= 1'b0;
		end else begin
			if (!pinfn_q.output_pin_function_bit) begin
				SERIAL_OUT_PIN_OUT <= SHARED_OUTPUT_PORT_DATA_IN;
			end else if (state_q == CSP_XFER) begin
				SERIAL_OUT_PIN_OUT <= so_bit_q;
			end else begin
				SERIAL_OUT_PIN_OUT <= idle_q;
			end
			SHARED_INPUT_PORT_DATA_OUT <= si_s;
			TRANSFER_CLOCK_PIN_OUT     <= clk_int_q;
			TRANSFER_CLOCK_PIN_OE_OUT  <= mode_q.sck_pin_sel && !ext_mode;
		end
	end

	assign PULL_TRANSISTOR_ENABLE_OUT = misc_q.pull_transistor_enable;

	// Timing period generator; long code selects the long period in every mode, all other codes the short one
	assign per_last = ({misc_q.timing_select_high, misc_q.timing_select_low} == `CSP_TSEL_LONG) ?
		TW'(TRC_LONG_CYC - 1) : TW'(TRC_SHORT_CYC - 1);
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			tcnt_q <= '0;
			tick_q <= 1'b0;
		end else if (tcnt_q >= per_last) begin
			tcnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			tcnt_q <= tcnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end
	assign TIMING_TICK_OUT = tick_q;

	// Interrupt status, write one to clear; a set in the same cycle wins
	always_comb begin
		stat_set                    = '0;
		stat_set[`CSP_IRQ_XFER_BIT] = wrap || (wr_mode && state_q == CSP_XFER);
		stat_set[`CSP_IRQ_TICK_BIT] = tick_q;
	end

	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= '0;
			mask_q <= '0;
		end else begin
			if (REG_WR_IN && REG_ADDR_IN == `CSP_OFF_IRQ_STAT) begin
				stat_q <= (stat_q & ~REG_WDATA_IN[1:0]) | stat_set;
			end else begin
				stat_q <= stat_q | stat_set;
			end
			if (REG_WR_IN && REG_ADDR_IN == `CSP_OFF_IRQ_MASK) begin
				mask_q <= REG_WDATA_IN[1:0];
			end
		end
	end

	assign IRQ_OUT = |(stat_q & mask_q);

	// Read port; write-only and unmapped addresses read zero
	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			REG_RDATA_OUT <= '0;
		end else if (REG_RD_IN) begin
			case (REG_ADDR_IN)
				`CSP_OFF_SR_LO:    REG_RDATA_OUT <= sr_q[3:0];
				`CSP_OFF_SR_HI:    REG_RDATA_OUT <= sr_q[7:4];
				`CSP_OFF_IRQ_STAT: REG_RDATA_OUT <= {2'h0, stat_q};
				`CSP_OFF_IRQ_MASK: REG_RDATA_OUT <= {2'h0, mask_q};
				`CSP_OFF_STATUS:   REG_RDATA_OUT <= {1'b0, state_q == CSP_XFER,
					state_q == CSP_CLK_WAIT, state_q == CSP_STS_WAIT};
				default:           REG_RDATA_OUT <= '0;
			endcase
		end else begin
			REG_RDATA_OUT <= '0;
		end
	end

	// Checks
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!rst_n);

	sequence xfer_fall_s;
		state_q == CSP_XFER && tclk_fall;
	endsequence

	sequence xfer_rise_s;
		state_q == CSP_XFER && tclk_rise;
	endsequence

	sequence quiet_s;
		!STOP_MODE_IN && !wr_mode;
	endsequence

	shift_out_a: assert property (xfer_fall_s |=> so_bit_q == $past(sr_q[0]))
		else $error("output bit not taken from shift register");
	sample_in_a: assert property (xfer_rise_s |=> sr_q[7] == $past(si_eff) && sr_q[6:0] == $past(sr_q[7:1]))
		else $error("input bit not sampled on rising edge");
	byte_hold_a: assert property (state_q != CSP_XFER && !wr_sr_lo && !wr_sr_hi |=> $stable(sr_q))
		else $error("shift register changed outside transfer");
	low_read_a: assert property (REG_RD_IN && REG_ADDR_IN == `CSP_OFF_SR_LO |=> REG_RDATA_OUT == $past(sr_q[3:0]))
		else $error("low nibble read mismatch");
	stop_clear_a: assert property (STOP_MODE_IN |=> pinfn_q == '0 && misc_q == '0)
		else $error("control registers not cleared by stop");
	port_pass_a: assert property (!pinfn_q.output_pin_function_bit |=> SERIAL_OUT_PIN_OUT == $past(SHARED_OUTPUT_PORT_DATA_IN))
		else $error("output pin not given to port");
	pull_follow_a: assert property (wr_misc && !STOP_MODE_IN |=> PULL_TRANSISTOR_ENABLE_OUT == $past(REG_WDATA_IN[3]))
		else $error("pull transistor control not applied");
	long_period_a: assert property (tick_q && $past(per_last) == TW'(TRC_LONG_CYC - 1) |-> $past(tcnt_q) >= TW'(TRC_LONG_CYC - 1))
		else $error("long timing period too short");
	wrap_flag_a: assert property (xfer_rise_s ##0 (cnt_q == `CSP_BIT_LAST) ##0 quiet_s |=> stat_q[0] && state_q == CSP_CLK_WAIT)
		else $error("wrap did not raise flag and wait");
	mode_abort_a: assert property (wr_mode && state_q == CSP_XFER |=> stat_q[0] && cnt_q == '0 && state_q == CSP_STS_WAIT)
		else $error("mode write did not abort transfer");
	idle_drive_a: assert property (pinfn_q.output_pin_function_bit && state_q != CSP_XFER |=> SERIAL_OUT_PIN_OUT == $past(idle_q))
		else $error("idle level not on output pin");

endmodule

// file: sim/csp_peer.sv
`timescale 1ns/100ps
// Far-side serial peer; external transfer clock
module csp_peer #(
	parameter int HALF_NS = 200
) (
	// Link pins
	output logic      sck_out,
	output logic      si_out,
	input  wire logic so_in
);
	initial begin
		sck_out = 1'b1;
		si_out  = 1'b0;
	end

	// Clock stands high outside frames
	task automatic frame(input logic [7:0] rx, input int nbits, output logic [7:0] got);
		got = 8'h00;
		#13;
		for (int i = 0; i < nbits; i++) begin
			sck_out = 1'b0;
			si_out  = rx[i];
			#(HALF_NS);
			sck_out = 1'b1;
			// Late sample allows for the pin sync latency
			#(HALF_NS / 2);
			got[i] = so_in;
			#(HALF_NS / 2);
		end
		// Released line must not keep the last bit
		si_out = ~si_out;
	endtask
endmodule

// file: sim/csp_top_test.sv
`timescale 1ns/100ps
`include "csp_params.svh"
module csp_top_test;
	localparam int LONG_CYC  = 40;
	localparam int SHORT_CYC = 2441;

	logic                   sys_clk, arst_n, wr, rd, stop, sh_out_data;
	logic [`CSP_ADDR_W-1:0] addr;
	logic [`CSP_DATA_W-1:0] wdata, rdata;
	logic                   sck_in, si, so, sck_out, sck_oe, pull, sh_in_data, tick, irq;
	logic [7:0]             got;
	logic [3:0]             d;
	int                     errors, n_tests, n;

	csp_top #(.TRC_LONG_CYC(LONG_CYC), .INT_HALF_CYC(4)) uut (
		.SYS_CLK_IN(sys_clk), .ARST_N_IN(arst_n),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_RDATA_OUT(rdata), .STOP_MODE_IN(stop),
		.TRANSFER_CLOCK_PIN_IN(sck_in), .TRANSFER_CLOCK_PIN_OUT(sck_out),
		.TRANSFER_CLOCK_PIN_OE_OUT(sck_oe), .SERIAL_IN_PIN_IN(si), .SERIAL_OUT_PIN_OUT(so),
		.PULL_TRANSISTOR_ENABLE_OUT(pull), .SHARED_OUTPUT_PORT_DATA_IN(sh_out_data),
		.SHARED_INPUT_PORT_DATA_OUT(sh_in_data), .TIMING_TICK_OUT(tick), .IRQ_OUT(irq)
	);

	csp_peer peer (.sck_out(sck_in), .si_out(si), .so_in(so));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [5:0] a, input logic [3:0] v);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr    <= 1'b0;
	endtask

	task automatic rd_reg(input logic [5:0] a, output logic [3:0] v);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd   <= 1'b0;
		@(negedge sys_clk);
		v = rdata;
	endtask

	task automatic wait_cyc(input int c);
		repeat (c) @(negedge sys_clk);
	endtask

	task automatic tick_gap(output int c);
		c = 0;
		while (tick !== 1'b1 && c < 6000) begin
			@(negedge sys_clk);
			c++;
		end
		c = 0;
		do begin
			@(negedge sys_clk);
			c++;
		end while (tick !== 1'b1 && c < 6000);
	endtask

	task automatic t_reset;
		rd_reg(6'h32, d);
		chk(d, 8'h01);
		rd_reg(6'h04, d);
		chk(d, 8'h00);
		rd_reg(6'h0c, d);
		chk(d, 8'h00);
		rd_reg(6'h3f, d);
		chk(d, 8'h00);
		chk(pull, 8'h00);
		chk({sck_out, sck_oe}, 8'h02);
		$display("t_reset done");
	endtask

	task automatic t_pins;
		@(posedge sys_clk);
		sh_out_data <= 1'b1;
		peer.si_out = 1'b1;
		wait_cyc(4);
		chk(so, 8'h01);
		chk(sh_in_data, 8'h01);
		peer.si_out = 1'b0;
		wr_reg(6'h04, 4'h1);
		wr_reg(6'h0c, 4'h8);
		wait_cyc(4);
		chk(so, 8'h00);
		chk(sh_in_data, 8'h00);
		chk(pull, 8'h01);
		@(posedge sys_clk);
		stop <= 1'b1;
		@(posedge sys_clk);
		stop <= 1'b0;
		wait_cyc(3);
		chk(so, 8'h01);
		chk(pull, 8'h00);
		$display("t_pins done");
	endtask

	task automatic t_tick;
		int exp_cyc [4];
		exp_cyc = '{SHORT_CYC, LONG_CYC, SHORT_CYC, SHORT_CYC};
		wr_reg(6'h31, 4'h2);
		for (int c = 0; c < 4; c++) begin
			wr_reg(6'h0c, c[3:0]);
			tick_gap(n);
			tick_gap(n);
			chk(n[7:0], exp_cyc[c][7:0]);
			chk(n[15:8], exp_cyc[c][15:8]);
		end
		chk(irq, 8'h01);
		wr_reg(6'h31, 4'h0);
		wait_cyc(1);
		chk(irq, 8'h00);
		wr_reg(6'h31, 4'h2);
		wr_reg(6'h30, 4'h2);
		wait_cyc(1);
		chk(irq, 8'h00);
		rd_reg(6'h30, d);
		chk(d, 8'h00);
		$display("t_tick done");
	endtask

	// Loads a byte, starts, runs a full frame, checks both directions
	task automatic run_byte(input logic [7:0] tx, input logic [7:0] rx);
		wr_reg(6'h06, tx[3:0]);
		wr_reg(6'h07, tx[7:4]);
		wr_reg(6'h2b, 4'h1);
		rd_reg(6'h32, d);
		chk(d, 8'h02);
		// No shift data access while the peer clocks
		peer.frame(rx, 8, got);
		chk(got, tx);
		wait_cyc(10);
		chk(so, 8'h01);
		chk(irq, 8'h01);
		rd_reg(6'h32, d);
		chk(d, 8'h02);
		rd_reg(6'h06, d);
		chk(d, {4'h0, rx[3:0]});
		rd_reg(6'h07, d);
		chk(d, {4'h0, rx[7:4]});
		wr_reg(6'h30, 4'h1);
	endtask

	task automatic t_xfer;
		wr_reg(6'h04, 4'h3);
		wr_reg(6'h28, 4'h2);
		wait_cyc(2);
		chk(so, 8'h01);
		wr_reg(6'h05, 4'hf);
		wr_reg(6'h31, 4'h1);
		run_byte(8'ha5, 8'h3c);
		$display("t_xfer done");
	endtask

	task automatic t_abort;
		peer.frame(8'hff, 3, got);
		wait_cyc(6);
		wr_reg(6'h05, 4'hf);
		wait_cyc(2);
		chk(irq, 8'h01);
		rd_reg(6'h32, d);
		chk(d, 8'h01);
		wr_reg(6'h30, 4'h1);
		run_byte(8'h5a, 8'h81);
		$display("t_abort done");
	endtask

	// Input function bit cleared: received bits must read as zero
	task automatic t_gate;
		wr_reg(6'h05, 4'hf);
		wr_reg(6'h04, 4'h1);
		wr_reg(6'h06, 4'h9);
		wr_reg(6'h07, 4'h6);
		wr_reg(6'h2b, 4'h1);
		peer.frame(8'hff, 8, got);
		chk(got, 8'h69);
		wait_cyc(10);
		chk(irq, 8'h01);
		rd_reg(6'h06, d);
		chk(d, 8'h00);
		rd_reg(6'h07, d);
		chk(d, 8'h00);
		wr_reg(6'h30, 4'h1);
		$display("t_gate done");
	endtask

	// Internal clock: device drives the link clock, peer holds its line high
	task automatic t_int;
		logic prev;
		int   k;
		peer.si_out = 1'b1;
		wr_reg(6'h05, 4'h8);
		wait_cyc(2);
		chk(sck_oe, 8'h01);
		wr_reg(6'h04, 4'h3);
		wr_reg(6'h06, 4'h3);
		wr_reg(6'h07, 4'hc);
		wr_reg(6'h2b, 4'h1);
		k    = 0;
		prev = 1'b1;
		got  = 8'h00;
		repeat (120) begin
			@(negedge sys_clk);
			if (sck_out === 1'b1 && prev === 1'b0) begin
				if (k < 8)
					got[k] = so;
				k++;
			end
			prev = sck_out;
		end
		chk(k[7:0], 8'h08);
		chk(got, 8'hc3);
		chk(irq, 8'h01);
		rd_reg(6'h32, d);
		chk(d, 8'h02);
		rd_reg(6'h06, d);
		chk(d, 8'h0f);
		rd_reg(6'h07, d);
		chk(d, 8'h0f);
		wr_reg(6'h30, 4'h1);
		$display("t_int done");
	endtask

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Tick scan dominates, about 22k cycles
	initial begin
		#3000000;
		errors++;
		complete_run();
	end

	initial begin
		errors      = 0;
		n_tests     = 0;
		arst_n      = 1'b0;
		wr          = 1'b0;
		rd          = 1'b0;
		stop        = 1'b0;
		sh_out_data = 1'b0;
		addr        = 6'h00;
		wdata       = 4'h0;
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_reset();
		t_pins();
		t_tick();
		t_xfer();
		t_abort();
		t_gate();
		t_int();
		complete_run();
	end
endmodule
